// *** dv/uart_shadow_data_port_test.sv ***
// self-checking bench of the shadow data port
`timescale 1ns/1ps
`include "usdp_cfg.svh"
module uart_shadow_data_port_test;
    import usdp_pkg::*;
    localparam usdp_word_type IDLE    = 32'h0000_0060;
    localparam usdp_word_type READY   = 32'h0000_0001;
    localparam usdp_word_type OE      = 32'h0000_0002;
    localparam usdp_word_type LINE_ST = `USDP_LINE_STATUS;
    logic          clk_sys;
    logic          rstn;
    usdp_word_type addr;
    usdp_word_type wdata;
    logic          wr_stb;
    logic          rd_stb;
    usdp_word_type rdata;
    logic          serial_rx;
    logic          serial_tx;
    logic          ir_rx;
    logic          ir_tx_n;
    logic          irq;
    logic          seen;
    int            errors;
    int            checks_done;
    int            cycles;
    usdp_top dut (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .serial_rx(serial_rx), .serial_tx(serial_tx), .ir_rx(ir_rx), .ir_tx_n(ir_tx_n), .irq(irq));
    usdp_peer u_peer (.clk_sys(clk_sys), .serial_tx(serial_tx), .serial_rx(serial_rx), .ir_rx(ir_rx));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic results;
        if (errors == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 100000) begin
            errors = errors + 1;
            $display("[FAIL] %0t timeout", $time);
            results();
        end
    end
    task automatic fail(input string msg);
        errors = errors + 1;
        $display("[FAIL] %0t %s", $time, msg);
    endtask
    task automatic wr(input usdp_word_type a, input usdp_word_type d);
        @(posedge clk_sys);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input usdp_word_type a, input usdp_word_type exp, input string msg);
        @(posedge clk_sys);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1;
        checks_done = checks_done + 1;
        if (rdata !== exp) fail(msg);
    endtask
    task automatic tx_expect(input usdp_byte_type exp, input string msg);
        for (int i = 0; i < 20000 && u_peer.txq.size() == 0; i++) @(posedge clk_sys);
        checks_done = checks_done + 1;
        if (u_peer.txq.size() == 0) fail(msg);
        else if (u_peer.txq.pop_front() !== exp) fail(msg);
    endtask
    task automatic t_reset;
        rd(`USDP_FIFO_CONTROL, 32'h0000_0000, "fifo control reset");
        rd(`USDP_INT_MASK, 32'h0000_0000, "mask reset");
        rd(LINE_ST, IDLE, "line status reset");
        rd(32'h5000_1070, 32'h0000_0000, "unmapped read");
        rd(32'h5000_104d, 32'h0000_0000, "unaligned read");
    endtask
    task automatic t_serial_rx;
        wr(`USDP_INT_MASK, OE);
        u_peer.send(8'h5a, 1'b0);
        rd(LINE_ST, IDLE | READY, "data ready missing");
        u_peer.send(8'ha5, 1'b0);
        checks_done = checks_done + 1;
        if (irq !== 1'b1) fail("overrun irq low");
        rd(LINE_ST, IDLE | READY | OE, "overrun missing");
        rd(`USDP_SHADOW_7, 32'h0000_00a5, "newer char not kept");
        rd(`USDP_INT_STATUS, 32'h0000_0003, "event status");
        checks_done = checks_done + 1;
        if (irq !== 1'b0) fail("irq not cleared");
    endtask
    task automatic t_serial_tx;
        wr(`USDP_SHADOW_8, 32'h0000_ab3c);
        wr(`USDP_SHADOW_8, 32'h0000_0011);
        rd(LINE_ST, 32'h0000_0000, "holding flag not cleared");
        wr(`USDP_SHADOW_8, 32'h0000_0022);
        tx_expect(8'h3c, "first char wrong");
        tx_expect(8'h22, "pending char not replaced");
    endtask
    task automatic t_fifo;
        wr(`USDP_FIFO_CONTROL, 32'h0000_0001);
        u_peer.send(8'h11, 1'b0);
        u_peer.send(8'h22, 1'b0);
        rd(`USDP_SHADOW_BASE, 32'h0000_0011, "fifo head wrong");
        rd(`USDP_SHADOW_BASE + 32'h0000_003c, 32'h0000_0022, "fifo second wrong");
        rd(LINE_ST, IDLE, "fifo not drained");
        for (int i = 0; i < 18; i++) wr(`USDP_SHADOW_BASE + 32'(4 * (i % 16)), 32'(i));
        rd(LINE_ST, 32'h0000_0000, "tx fifo empty flag");
        tx_expect(8'h00, "fifo tx first");
        tx_expect(8'h01, "fifo tx order");
        wr(`USDP_FIFO_CONTROL, 32'h0000_0001);
    endtask
    task automatic t_ir;
        wr(`USDP_FIFO_CONTROL, 32'h0000_0002);
        u_peer.send(8'h96, 1'b1);
        rd(LINE_ST, IDLE | READY, "ir data ready");
        rd(`USDP_SHADOW_7, 32'h0000_0096, "ir char wrong");
        wr(`USDP_SHADOW_7, 32'h0000_000f);
        seen = 1'b0;
        repeat (2000) @(posedge clk_sys) if (ir_tx_n === 1'b0) seen = 1'b1;
        checks_done = checks_done + 1;
        if (seen !== 1'b1) fail("no ir pulse");
    endtask
    initial begin
        rstn        = 1'b0;
        addr        = 32'h0000_0000;
        wdata       = 32'h0000_0000;
        wr_stb      = 1'b0;
        rd_stb      = 1'b0;
        errors      = 0;
        checks_done = 0;
        cycles      = 0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_serial_rx();
        t_serial_tx();
        t_fifo();
        t_ir();
        results();
    end
endmodule // uart_shadow_data_port_test

// *** dv/usdp_chk_sva.sv ***
// assertions on the shadow data port outputs
`timescale 1ns/1ps
`include "usdp_cfg.svh"
module usdp_chk (
    // clock and reset
    input wire logic                    clk_sys,
    input wire logic                    rstn,
    // register port
    input wire usdp_pkg::usdp_word_type addr,
    input wire usdp_pkg::usdp_word_type wdata,
    input wire logic                    wr_stb,
    input wire logic                    rd_stb,
    input wire usdp_pkg::usdp_word_type rdata,
    // lines and interrupt
    input wire logic                    serial_tx,
    input wire logic                    ir_tx_n,
    input wire logic                    irq
);
    import usdp_pkg::*;
    localparam int IR_PULSE = `USDP_IR_PULSE_CYC;
    localparam int BIT_CYC  = `USDP_BIT_CYC;
    logic        ir_r;
    logic [2:0]  mask_r;
    logic [15:0] ir_low_r;
    logic [15:0] tx_low_r;
    logic        shadow;
    logic        mapped;
    assign shadow = addr >= `USDP_SHADOW_BASE && addr <= `USDP_SHADOW_BASE + 32'h0000_003c && addr[1:0] == 2'h0;
    assign mapped = shadow || (addr >= `USDP_LINE_STATUS && addr <= `USDP_INT_MASK && addr[1:0] == 2'h0);
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ir_r   <= 1'b0;
            mask_r <= 3'h0;
        end else if (wr_stb && addr == `USDP_FIFO_CONTROL) begin
            ir_r <= wdata[1];
        end else if (wr_stb && addr == `USDP_INT_MASK) begin
            mask_r <= wdata[2:0];
        end
    end
    // length of the current low run on each output
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ir_low_r <= 16'h0000;
            tx_low_r <= 16'h0000;
        end else begin
            ir_low_r <= ir_tx_n ? 16'h0000 : ir_low_r + 16'h0001;
            tx_low_r <= serial_tx ? 16'h0000 : tx_low_r + 16'h0001;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    AST_RDATA_HOLD: assert property (!$past(rd_stb) |-> $stable(rdata))
        else $error("rdata changed without a read");
    AST_UNMAPPED_ZERO: assert property (rd_stb && !mapped |=> rdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    AST_SHADOW_UPPER_ZERO: assert property (rd_stb && shadow |=> rdata[31:8] == 24'h00_0000)
        else $error("shadow upper bits not zero");
    AST_IR_SERIAL_IDLE: assert property (ir_r && $past(ir_r) |-> serial_tx)
        else $error("serial line moved in infrared mode");
    AST_SERIAL_IR_IDLE: assert property (!ir_r && !$past(ir_r) |-> ir_tx_n)
        else $error("infrared line moved in serial mode");
    AST_IRQ_MASKED: assert property (mask_r == 3'h0 && $past(mask_r) == 3'h0 |-> !irq)
        else $error("irq with all events masked");
    AST_IR_PULSE_LEN: assert property ($rose(ir_tx_n) |-> ir_low_r == IR_PULSE)
        else $error("infrared pulse length wrong");
    AST_TX_BIT_LEN: assert property ($rose(serial_tx) |-> tx_low_r % BIT_CYC == 0 && tx_low_r != 0)
        else $error("serial low run not whole bits");
endmodule // usdp_chk

bind usdp_top usdp_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rdata(rdata), .serial_tx(serial_tx), .ir_tx_n(ir_tx_n), .irq(irq));

// *** dv/usdp_peer.sv ***
// remote serial peer: drives the receive lines, collects characters sent on serial_tx
`timescale 1ns/1ps
`include "usdp_cfg.svh"
module usdp_peer (
    // clock
    input wire logic clk_sys,
    // lines
    input wire logic serial_tx,
    output logic     serial_rx,
    output logic     ir_rx
);
    import usdp_pkg::*;
    usdp_byte_type txq[$];
    usdp_byte_type got;
    initial begin
        serial_rx = 1'b1;
        ir_rx     = 1'b1;
    end
    // 8N1, lsb first, on the chosen line; the other stays idle high
    task automatic send(input usdp_byte_type b, input logic ir);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        @(posedge clk_sys);
        for (int i = 0; i < 10; i++) begin
            if (ir)
                ir_rx <= frame[i];
            else
                serial_rx <= frame[i];
            repeat (`USDP_BIT_CYC) @(posedge clk_sys);
        end
    endtask
    // sample mid-bit after the start edge
    always begin
        @(negedge serial_tx);
        repeat (`USDP_BIT_CYC / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (`USDP_BIT_CYC) @(posedge clk_sys);
            got[i] = serial_tx;
        end
        repeat (`USDP_BIT_CYC) @(posedge clk_sys);
        txq.push_back(got);
    end
endmodule // usdp_peer

// *** rtl/usdp_cfg.svh ***
// constants of the shadow data port: offsets, fields, resets, timing
//
// Function
// - shadow read returns received byte, serial or infrared
// - sixteen word-spaced shadow locations alias rx/tx
// - no fifo: new char overwrites, flags overrun
// - fifo mode: read returns receive fifo head
// - rx fifo full: keep contents, drop, overrun
// - shadow write sends character, serial or infrared
// - no fifo: one write clears holding-empty flag
// - no fifo: further writes replace pending character
// - fifo mode: transmit fifo accepts sixteen characters
// - write to full transmit fifo is discarded
`ifndef USDP_CFG_SVH
`define USDP_CFG_SVH

`define USDP_SHADOW_BASE    32'h5000_1030
`define USDP_SHADOW_7       32'h5000_104c
`define USDP_SHADOW_8       32'h5000_1050
`define USDP_SHADOW_COUNT   16
`define USDP_LINE_STATUS    32'h5000_1080
`define USDP_FIFO_CONTROL   32'h5000_1084
`define USDP_INT_STATUS     32'h5000_1088
`define USDP_INT_MASK       32'h5000_108c

`define USDP_DATA_W         8
`define USDP_FIFO_DEPTH     16
`define USDP_PTR_W          4
`define USDP_CNT_W          5

`define USDP_STAT_READY     0
`define USDP_STAT_OVERRUN   1
`define USDP_STAT_TX_EMPTY  5
`define USDP_STAT_TX_IDLE   6
`define USDP_CTRL_FIFO_EN   0
`define USDP_CTRL_IR_MODE   1
`define USDP_INT_RX         0
`define USDP_INT_OVR        1
`define USDP_INT_TXE        2
`define USDP_INT_W          3

`define USDP_CTRL_RESET     2'h0
`define USDP_MASK_RESET     3'h0

`define USDP_CLK_PERIOD_NS  10
`define USDP_BIT_TIME_NS    8680
`define USDP_BIT_CYC        (`USDP_BIT_TIME_NS / `USDP_CLK_PERIOD_NS)
`define USDP_IR_PULSE_CYC   ((`USDP_BIT_CYC * 3) / 16)

`endif

// *** rtl/usdp_pkg.sv ***
// types of the shadow data port
package usdp_pkg;
    typedef enum logic [1:0] {SER_IDLE, SER_START, SER_DATA, SER_STOP} usdp_ser_state_type;
    typedef logic [7:0]  usdp_byte_type;
    typedef logic [31:0] usdp_word_type;
endpackage

// *** rtl/usdp_top.sv ***
// shadow data port: register slave, rx/tx fifos, serial and infrared character engines
`timescale 1ns/1ps
`include "usdp_cfg.svh"
module usdp_top (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rstn,
    // register port
    input  wire usdp_pkg::usdp_word_type addr,
    input  wire usdp_pkg::usdp_word_type wdata,
    input  wire logic               wr_stb,
    input  wire logic               rd_stb,
    output usdp_pkg::usdp_word_type rdata,
    // serial and infrared lines
    input  wire logic               serial_rx,
    output logic                    serial_tx,
    input  wire logic               ir_rx,
    output logic                    ir_tx_n,
    // interrupt
    output logic                    irq
);
    import usdp_pkg::*;

    localparam logic [15:0] BIT_CYC  = 16'(`USDP_BIT_CYC);
    localparam logic [15:0] HALF_CYC = 16'(`USDP_BIT_CYC / 2);
    localparam logic [15:0] IR_CYC   = 16'(`USDP_IR_PULSE_CYC);

    // control and status storage
    logic [1:0]                ctrl_r;
    logic [`USDP_INT_W-1:0]    mask_r;
    logic [`USDP_INT_W-1:0]    int_r;
    logic                      ovr_r;
    usdp_word_type             rdata_r;

    logic [`USDP_DATA_W-1:0]   rx_mem [`USDP_FIFO_DEPTH];
    logic [`USDP_DATA_W-1:0]   tx_mem [`USDP_FIFO_DEPTH];
    logic [`USDP_PTR_W-1:0]    rx_wp_r, rx_rp_r, tx_wp_r, tx_rp_r;
    logic [`USDP_CNT_W-1:0]    rx_cnt_r, tx_cnt_r;

    logic                      fifo_en, ir_mode;
    logic                      shadow_hit, rd_shadow, wr_shadow, wr_ctrl;
    logic                      rx_done, rx_push, rx_ovw, rx_pop, rx_full, rx_drop;
    logic                      tx_push, tx_ovw, tx_pop, tx_full;
    logic [`USDP_DATA_W-1:0]   rx_byte_r;
    logic                      tx_empty_now, tx_empty_d_r;
    usdp_ser_state_type        tx_st_r;

    assign fifo_en    = ctrl_r[`USDP_CTRL_FIFO_EN];
    assign ir_mode    = ctrl_r[`USDP_CTRL_IR_MODE];
    // sixteen aliased word locations
    assign shadow_hit = (addr >= `USDP_SHADOW_BASE) &&
                        (addr < `USDP_SHADOW_BASE + 32'(4 * `USDP_SHADOW_COUNT)) &&
                        (addr[1:0] == 2'h0);
    assign rd_shadow  = rd_stb && shadow_hit;
    assign wr_shadow  = wr_stb && shadow_hit;
    assign wr_ctrl    = wr_stb && (addr == `USDP_FIFO_CONTROL);

    // receive fifo control
    assign rx_full = (rx_cnt_r == 5'(`USDP_FIFO_DEPTH));
    assign rx_pop  = rd_shadow && (rx_cnt_r != 5'h0);
    assign rx_ovw  = rx_done && !fifo_en && (rx_cnt_r != 5'h0) && !rx_pop;
    assign rx_drop = rx_done && fifo_en && rx_full && !rx_pop;
    assign rx_push = rx_done && !rx_ovw && !rx_drop;

    always_ff @(posedge clk_sys) begin
        if (!rstn || wr_ctrl) begin
            rx_wp_r  <= 4'h0;
            rx_rp_r  <= 4'h0;
            rx_cnt_r <= 5'h0;
        end else begin
            if (rx_push) begin
                rx_mem[rx_wp_r] <= rx_byte_r;
                rx_wp_r         <= rx_wp_r + 4'h1;
            end
            if (rx_ovw) begin
                rx_mem[rx_rp_r] <= rx_byte_r;
            end
            if (rx_pop) begin
                rx_rp_r <= rx_rp_r + 4'h1;
            end
            rx_cnt_r <= rx_cnt_r + 5'(rx_push) - 5'(rx_pop);
        end
    end

    // transmit fifo control
    assign tx_full = fifo_en ? (tx_cnt_r == 5'(`USDP_FIFO_DEPTH)) : (tx_cnt_r != 5'h0);
    assign tx_ovw  = wr_shadow && !fifo_en && (tx_cnt_r != 5'h0) && !tx_pop;
    // no fifo: a write landing as the pending char leaves becomes the new pending char
    assign tx_push = wr_shadow && (!tx_full || (!fifo_en && tx_pop));

    always_ff @(posedge clk_sys) begin
        if (!rstn || wr_ctrl) begin
            tx_wp_r  <= 4'h0;
            tx_rp_r  <= 4'h0;
            tx_cnt_r <= 5'h0;
        end else begin
            if (tx_push) begin
                tx_mem[tx_wp_r] <= wdata[7:0];
                tx_wp_r         <= tx_wp_r + 4'h1;
            end
            if (tx_ovw) begin
                tx_mem[tx_rp_r] <= wdata[7:0];
            end
            if (tx_pop) begin
                tx_rp_r <= tx_rp_r + 4'h1;
            end
            tx_cnt_r <= tx_cnt_r + 5'(tx_push) - 5'(tx_pop);
        end
    end

    // control and mask registers
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ctrl_r <= `USDP_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_r <= wdata[1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mask_r <= `USDP_MASK_RESET;
        end else if (wr_stb && addr == `USDP_INT_MASK) begin
            mask_r <= wdata[`USDP_INT_W-1:0];
        end
    end

    // overrun flag, cleared by line status read, set wins
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ovr_r <= 1'b0;
        end else if (rx_ovw || rx_drop) begin
            ovr_r <= 1'b1;
        end else if (rd_stb && addr == `USDP_LINE_STATUS) begin
            ovr_r <= 1'b0;
        end
    end

    // sticky interrupt events, cleared by status read, set wins
    logic [`USDP_INT_W-1:0] int_set;
    assign tx_empty_now = (tx_cnt_r == 5'h0);
    always_comb begin
        int_set                = '0;
        int_set[`USDP_INT_RX]  = rx_push || rx_ovw;
        int_set[`USDP_INT_OVR] = rx_ovw || rx_drop;
        int_set[`USDP_INT_TXE] = tx_empty_now && !tx_empty_d_r;
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tx_empty_d_r <= 1'b1;
        end else begin
            tx_empty_d_r <= tx_empty_now;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            int_r <= '0;
        end else if (rd_stb && addr == `USDP_INT_STATUS) begin
            int_r <= int_set;
        end else begin
            int_r <= int_r | int_set;
        end
    end

    assign irq = |(int_r & mask_r);

    // read data, one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rdata_r <= 32'h0000_0000;
        end else if (rd_stb) begin
            rdata_r <= 32'h0000_0000;
            if (shadow_hit) begin
                rdata_r[7:0] <= rx_mem[rx_rp_r];
            end else if (addr == `USDP_LINE_STATUS) begin
                rdata_r[`USDP_STAT_READY]    <= (rx_cnt_r != 5'h0);
                rdata_r[`USDP_STAT_OVERRUN]  <= ovr_r;
                rdata_r[`USDP_STAT_TX_EMPTY] <= tx_empty_now;
                rdata_r[`USDP_STAT_TX_IDLE]  <= tx_empty_now && (tx_st_r == SER_IDLE);
            end else if (addr == `USDP_FIFO_CONTROL) begin
                rdata_r[1:0] <= ctrl_r;
            end else if (addr == `USDP_INT_STATUS) begin
                rdata_r[`USDP_INT_W-1:0] <= int_r;
            end else if (addr == `USDP_INT_MASK) begin
                rdata_r[`USDP_INT_W-1:0] <= mask_r;
            end
        end
    end

    assign rdata = rdata_r;

    // receive line: two-stage synchronisers, then mode select
    logic ser_s1_r, ser_s2_r, ir_s1_r, ir_s2_r, rx_line;
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ser_s1_r <= 1'b1;
            ser_s2_r <= 1'b1;
            ir_s1_r  <= 1'b1;
            ir_s2_r  <= 1'b1;
        end else begin
            ser_s1_r <= serial_rx;
            ser_s2_r <= ser_s1_r;
            ir_s1_r  <= ir_rx;
            ir_s2_r  <= ir_s1_r;
        end
    end
    assign rx_line = ir_mode ? ir_s2_r : ser_s2_r;

    // receive engine, 8 data bits, one stop bit, sampled mid-bit
    usdp_ser_state_type rx_st_r;
    logic [15:0]        rx_tmr_r;
    logic [2:0]         rx_bit_r;
    logic [7:0]         rx_sh_r;
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            rx_st_r   <= SER_IDLE;
            rx_tmr_r  <= 16'h0000;
            rx_bit_r  <= 3'h0;
            rx_sh_r   <= 8'h00;
            rx_byte_r <= 8'h00;
            rx_done   <= 1'b0;
        end else begin
            rx_done <= 1'b0;
            case (rx_st_r)
                SER_IDLE: begin
                    if (!rx_line) begin
                        rx_st_r  <= SER_START;
                        rx_tmr_r <= HALF_CYC;
                    end
                end
                SER_START: begin
                    if (rx_tmr_r != 16'h0000) begin
                        rx_tmr_r <= rx_tmr_r - 16'h0001;
                    end else if (rx_line) begin
                        rx_st_r <= SER_IDLE;
                    end else begin
                        rx_st_r  <= SER_DATA;
                        rx_tmr_r <= BIT_CYC - 16'h0001;
                        rx_bit_r <= 3'h0;
                    end
                end
                SER_DATA: begin
                    if (rx_tmr_r != 16'h0000) begin
                        rx_tmr_r <= rx_tmr_r - 16'h0001;
                    end else begin
                        rx_sh_r  <= {rx_line, rx_sh_r[7:1]};
                        rx_tmr_r <= BIT_CYC - 16'h0001;
                        rx_bit_r <= rx_bit_r + 3'h1;
                        if (rx_bit_r == 3'h7) begin
                            rx_st_r <= SER_STOP;
                        end
                    end
                end
                SER_STOP: begin
                    if (rx_tmr_r != 16'h0000) begin
                        rx_tmr_r <= rx_tmr_r - 16'h0001;
                    end else begin
                        rx_byte_r <= rx_sh_r;
                        rx_done   <= 1'b1;
                        rx_st_r   <= SER_IDLE;
                    end
                end
                default: rx_st_r <= SER_IDLE;
            endcase
        end
    end

    // transmit engine, pulls from the transmit fifo when idle
    logic [15:0]        tx_tmr_r;
    logic [2:0]         tx_bit_r;
    logic [7:0]         tx_sh_r;
    logic               tx_lvl_r;
    assign tx_pop = (tx_st_r == SER_IDLE) && (tx_cnt_r != 5'h0);
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            tx_st_r  <= SER_IDLE;
            tx_tmr_r <= 16'h0000;
            tx_bit_r <= 3'h0;
            tx_sh_r  <= 8'h00;
            tx_lvl_r <= 1'b1;
        end else begin
            case (tx_st_r)
                SER_IDLE: begin
                    tx_lvl_r <= 1'b1;
                    if (tx_pop) begin
                        tx_sh_r  <= tx_mem[tx_rp_r];
                        tx_st_r  <= SER_START;
                        tx_tmr_r <= BIT_CYC - 16'h0001;
                        tx_lvl_r <= 1'b0;
                    end
                end
                SER_START, SER_DATA: begin
                    if (tx_tmr_r != 16'h0000) begin
                        tx_tmr_r <= tx_tmr_r - 16'h0001;
                    end else begin
                        tx_tmr_r <= BIT_CYC - 16'h0001;
                        if (tx_st_r == SER_START) begin
                            tx_st_r  <= SER_DATA;
                            tx_bit_r <= 3'h0;
                            tx_lvl_r <= tx_sh_r[0];
                        end else if (tx_bit_r == 3'h7) begin
                            tx_st_r  <= SER_STOP;
                            tx_lvl_r <= 1'b1;
                        end else begin
                            tx_bit_r <= tx_bit_r + 3'h1;
                            tx_lvl_r <= tx_sh_r[tx_bit_r + 3'h1];
                        end
                    end
                end
                SER_STOP: begin
                    if (tx_tmr_r != 16'h0000) begin
                        tx_tmr_r <= tx_tmr_r - 16'h0001;
                    end else begin
                        tx_st_r <= SER_IDLE;
                    end
                end
                default: tx_st_r <= SER_IDLE;
            endcase
        end
    end

    // line outputs: serial level or short infrared pulse per zero bit
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            serial_tx <= 1'b1;
            ir_tx_n   <= 1'b1;
        end else begin
            serial_tx <= ir_mode ? 1'b1 : tx_lvl_r;
            ir_tx_n   <= !(ir_mode && !tx_lvl_r && (tx_tmr_r >= BIT_CYC - IR_CYC));
        end
    end

endmodule // usdp_top
